/* File: shared/apwt_pkg.sv */
// Shared constants of the autonomous periodic wakeup timer
package apwt_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_CTRL = 10'h2F2;
  localparam logic [9:0] IDX_TRIM = 10'h2F3;
  localparam logic [9:0] IDX_RLDH = 10'h2F4;
  localparam logic [9:0] IDX_RLDL = 10'h2F5;
  localparam int ADDR_W = 12;

  // ---------------------------------------------------------------
  // Control and trim register fields
  // ---------------------------------------------------------------
  localparam int CTL_CSEL = 7;
  localparam int CTL_WSEL = 4;
  localparam int CTL_PEN = 3;
  localparam int CTL_FEN = 2;
  localparam int CTL_IEN = 1;
  localparam int CTL_FLAG = 0;
  localparam int TRIM_LSB = 2;
  localparam int TRIM_W = 6;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] TRIM_RST = 6'h00;
  localparam logic [15:0] RLD_RST = 16'h0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ACLK_PERIOD_US = 100;
  localparam int ACLK_CYCLES = (ACLK_PERIOD_US * 1000000) / CLK_PERIOD_PS;
  localparam int TRIM_STEP_CYCLES = 64;

  typedef enum logic {
    APWT_IDLE,
    APWT_RUN
  } apwt_state_t;
endpackage : apwt_pkg

/* File: rtl/apwt_aclk_div.sv */
// Trimmable divider standing in for the autonomous low-power clock
`timescale 1ns/1ps
module apwt_aclk_div #(
  parameter int BASE_CYCLES = 25000,
  parameter int STEP_CYCLES = 64
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [5:0] i_trim,
  output logic o_tick
);
  localparam int CW = $clog2(BASE_CYCLES + 33 * STEP_CYCLES + 1);

  if (BASE_CYCLES <= 32 * STEP_CYCLES) begin : g_chk
    $error("apwt_aclk_div: base period too short for the trim range");
  end

  logic [CW-1:0] cnt;
  logic [CW-1:0] limit;

  // Signed trim: negative values lengthen the period, positive shorten it
  always_comb begin
    limit = CW'(BASE_CYCLES - $signed(i_trim) * STEP_CYCLES - 1);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt <= '0;
      o_tick <= 1'b0;
    end else if (cnt >= limit) begin
      cnt <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule : apwt_aclk_div

/* File: rtl/apwt_half_cnt.sv */
// Reloading down counter that marks each half of the timeout period
`timescale 1ns/1ps
module apwt_half_cnt #(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic [W-1:0] i_reload,
  output logic o_half
);
  if (W < 1) begin : g_chk
    $error("apwt_half_cnt: width must be positive");
  end

  logic [W-1:0] cnt;

  assign o_half = i_run && i_tick && (cnt == '0);

  // Held at the reload value while stopped so a start sees a full period
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_run) begin
      cnt <= i_reload;
    end else if (i_tick) begin
      cnt <= (cnt == '0) ? i_reload : cnt - 1'b1;
    end
  end

  AST_HALF_RELOAD: assert property (@(posedge i_clk) disable iff (i_srst)
    o_half && $stable(i_reload) |=> cnt == i_reload)
    else $error("Counter did not reload after half period");
endmodule : apwt_half_cnt

/* File: rtl/apwt_top.sv */
// Autonomous periodic wakeup timer with APB registers
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module apwt_top #(
  parameter int ACLK_CYCLES = apwt_pkg::ACLK_CYCLES,
  parameter int TRIM_STEP = apwt_pkg::TRIM_STEP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [apwt_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [5:0] i_flash_trim,
  output logic o_irq,
  output logic o_wave_pin
);
  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic clk_sel;
  logic wave_sel;
  logic pin_en;
  logic feat_en;
  logic irq_en;
  logic flag;
  logic next_flag;
  logic [5:0] trim;
  logic [15:0] reload;
  logic trim_loaded;
  logic phase;
  logic square;
  logic pulse;
  logic aclk_tick;
  logic tick;
  logic half;
  logic timeout;
  apwt_pkg::apwt_state_t state;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic [9:0] idx;
  logic setup;
  logic wr;
  logic hit;
  logic wr_ctrl;
  logic [7:0] wbyte;

  assign idx = i_paddr[11:2];
  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && i_pwrite && o_pready;
  assign wbyte = i_pwdata[7:0];
  assign hit = (idx == apwt_pkg::IDX_CTRL) || (idx == apwt_pkg::IDX_TRIM) ||
               (idx == apwt_pkg::IDX_RLDH) || (idx == apwt_pkg::IDX_RLDL);
  assign wr_ctrl = wr && (idx == apwt_pkg::IDX_CTRL);

  // Zero wait states: ready is raised for exactly the access cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup && !hit;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup) begin
      case (idx)
        apwt_pkg::IDX_CTRL: o_prdata <= {24'h000000, clk_sel, 2'b00, wave_sel, pin_en, feat_en, irq_en, flag};
        apwt_pkg::IDX_TRIM: o_prdata <= {24'h000000, trim, 2'b00};
        apwt_pkg::IDX_RLDH: o_prdata <= {24'h000000, reload[15:8]};
        apwt_pkg::IDX_RLDL: o_prdata <= {24'h000000, reload[7:0]};
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wave_sel <= apwt_pkg::CTRL_RST[apwt_pkg::CTL_WSEL];
      pin_en <= apwt_pkg::CTRL_RST[apwt_pkg::CTL_PEN];
      feat_en <= apwt_pkg::CTRL_RST[apwt_pkg::CTL_FEN];
      irq_en <= apwt_pkg::CTRL_RST[apwt_pkg::CTL_IEN];
    end else if (wr_ctrl) begin
      wave_sel <= wbyte[apwt_pkg::CTL_WSEL];
      pin_en <= wbyte[apwt_pkg::CTL_PEN];
      feat_en <= wbyte[apwt_pkg::CTL_FEN];
      irq_en <= wbyte[apwt_pkg::CTL_IEN];
    end
  end

  // Source may not change under a running timer, nor in the enabling write
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      clk_sel <= apwt_pkg::CTRL_RST[apwt_pkg::CTL_CSEL];
    end else if (wr_ctrl && !feat_en && !wbyte[apwt_pkg::CTL_FEN]) begin
      clk_sel <= wbyte[apwt_pkg::CTL_CSEL];
    end
  end

  // Set wins over a clear landing in the same cycle
  always_comb begin
    next_flag = flag;
    if (wr_ctrl && wbyte[apwt_pkg::CTL_FLAG]) begin
      next_flag = 1'b0;
    end
    if (timeout) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      flag <= apwt_pkg::CTRL_RST[apwt_pkg::CTL_FLAG];
      o_irq <= 1'b0;
    end else begin
      flag <= next_flag;
      o_irq <= next_flag && irq_en;
    end
  end

  // ---------------------------------------------------------------
  // Trim and reload registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      trim <= apwt_pkg::TRIM_RST;
      trim_loaded <= 1'b0;
    end else if (!trim_loaded) begin
      trim <= i_flash_trim;
      trim_loaded <= 1'b1;
    end else if (wr && idx == apwt_pkg::IDX_TRIM) begin
      trim <= wbyte[apwt_pkg::TRIM_LSB +: apwt_pkg::TRIM_W];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      reload <= apwt_pkg::RLD_RST;
    end else if (wr && !feat_en && idx == apwt_pkg::IDX_RLDH) begin
      reload[15:8] <= wbyte;
    end else if (wr && !feat_en && idx == apwt_pkg::IDX_RLDL) begin
      reload[7:0] <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // Timer core
  // ---------------------------------------------------------------
  apwt_aclk_div #(
    .BASE_CYCLES(ACLK_CYCLES),
    .STEP_CYCLES(TRIM_STEP)
  ) u_aclk (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_trim(trim),
    .o_tick(aclk_tick)
  );

  assign tick = clk_sel ? 1'b1 : aclk_tick;

  apwt_half_cnt #(
    .W(16)
  ) u_cnt (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_run(feat_en),
    .i_tick(tick),
    .i_reload(reload),
    .o_half(half)
  );

  // Two halves of reload plus one ticks make one period
  assign timeout = half && phase;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= apwt_pkg::APWT_IDLE;
      phase <= 1'b0;
    end else begin
      case (state)
        apwt_pkg::APWT_IDLE: begin
          // A half that ends in the start cycle must count, or a zero reload loses one tick
          phase <= half;
          if (feat_en) begin
            state <= apwt_pkg::APWT_RUN;
          end
        end
        apwt_pkg::APWT_RUN: begin
          if (!feat_en) begin
            state <= apwt_pkg::APWT_IDLE;
            phase <= 1'b0;
          end else if (half) begin
            phase <= !phase;
          end
        end
        default: begin
          state <= apwt_pkg::APWT_IDLE;
          phase <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin waveforms
  // ---------------------------------------------------------------
  // Pulse lasts one tick, i.e. half of the shortest period
  always_ff @(posedge i_clk) begin
    if (i_srst || !feat_en) begin
      pulse <= 1'b0;
      square <= 1'b0;
    end else begin
      if (timeout) begin
        pulse <= 1'b1;
        square <= !square;
      end else if (tick) begin
        pulse <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_wave_pin <= 1'b0;
    end else begin
      o_wave_pin <= pin_en && feat_en && (wave_sel ? square : pulse);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_bus_pulse;
    pulse ##1 !pulse;
  endsequence

  AST_SRC_LOCK: assert property (@(posedge i_clk) disable iff (i_srst)
    (feat_en || (wr_ctrl && wbyte[apwt_pkg::CTL_FEN])) |=> $stable(clk_sel))
    else $error("Source select changed while locked");

  AST_BUS_PULSE: assert property (@(posedge i_clk) disable iff (i_srst)
    timeout && clk_sel && feat_en && !wr_ctrl ##1 feat_en && !half |-> s_bus_pulse)
    else $error("Bus clock pulse not one cycle wide");

  AST_SQUARE_TOGGLE: assert property (@(posedge i_clk) disable iff (i_srst)
    timeout && !wr_ctrl |=> square != $past(square))
    else $error("Square wave did not toggle at timeout");

  AST_PIN_GATE: assert property (@(posedge i_clk) disable iff (i_srst)
    !(pin_en && feat_en) |=> !o_wave_pin)
    else $error("Pin driven while gated off");

  AST_START: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(feat_en) |-> ##[0:1] state == apwt_pkg::APWT_RUN)
    else $error("Timer did not start on enable");

  AST_FLAG_SET: assert property (@(posedge i_clk) disable iff (i_srst)
    timeout |=> flag)
    else $error("Timeout did not set flag");

  AST_FLAG_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
    flag && !(wr_ctrl && wbyte[apwt_pkg::CTL_FLAG]) |=> flag)
    else $error("Flag cleared without a written one");

  AST_IRQ: assert property (@(posedge i_clk) disable iff (i_srst)
    (flag && irq_en && !wr_ctrl |=> o_irq) and (!irq_en |=> !o_irq))
    else $error("Interrupt output disagrees with flag and enable");

  AST_TRIM_LOAD: assert property (@(posedge i_clk) disable iff (i_srst)
    !trim_loaded |=> trim_loaded && trim == $past(i_flash_trim))
    else $error("Trim not loaded from flash after reset");

  AST_RELOAD_LOCK: assert property (@(posedge i_clk) disable iff (i_srst)
    feat_en |=> $stable(reload))
    else $error("Reload changed while enabled");

  AST_BUS_HALF: assert property (@(posedge i_clk) disable iff (i_srst)
    half && clk_sel && feat_en && reload == 16'h0000 && !wr_ctrl |=> half)
    else $error("Zero reload did not give two-cycle period");
endmodule : apwt_top

/* File: testbench/apwt_top_test.sv */
// Self-checking bench of the periodic wakeup timer, driven over APB
`timescale 1ns/1ps
module apwt_top_test;
  logic i_clk;
  logic i_srst;
  logic i_psel;
  logic i_penable;
  logic i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata;
  logic [31:0] o_prdata;
  logic [31:0] rd;
  logic o_pready;
  logic o_pslverr;
  logic o_irq;
  logic o_wave_pin;
  logic err;
  logic prev = 1'b0;
  logic [5:0] i_flash_trim;
  int fail_count = 0;
  int checked = 0;
  int since = 0;
  int hi = 0;
  int per = 0;
  int hlen = 0;
  int rises = 0;
  int r0;

  // Small divider keeps the autonomous periods short; trim steps are one cycle each
  apwt_top #(.ACLK_CYCLES(40), .TRIM_STEP(1)) i_apwt_top (
    .i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_flash_trim(i_flash_trim),
    .o_irq(o_irq), .o_wave_pin(o_wave_pin)
  );

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------
  // Pin monitor: rise-to-rise period and high length in clock cycles
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    prev <= o_wave_pin;
    since <= since + 1;
    hi <= (o_wave_pin === 1'b1) ? hi + 1 : 0;
    if (o_wave_pin === 1'b1 && prev === 1'b0) begin
      per <= since;
      since <= 1;
      rises <= rises + 1;
    end
    if (o_wave_pin === 1'b0 && prev === 1'b1) begin
      hlen <= hi;
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waiting one edge first keeps a release and the next setup in different time steps
  task apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= {idx, 2'b00};
    i_pwdata <= {24'h000000, wd};
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      give_verdict();
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask : rdchk

  // Runs the timer for three full periods plus four cycles, then stops it
  task measure(input logic [7:0] ctl, input int p, input int h);
    apb(1'b1, apwt_pkg::IDX_CTRL, ctl);
    repeat (3 * p + 4) @(posedge i_clk);
    chk(32'(per), 32'(p));
    chk(32'(hlen), 32'(h));
    chk({31'h0, o_irq}, {31'h0, ctl[1]});
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h00);
  endtask : measure

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    i_srst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h00000000;
    i_flash_trim = 6'h2A;
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    rdchk(apwt_pkg::IDX_CTRL, 8'h00);
    rdchk(apwt_pkg::IDX_TRIM, 8'hA8);
    rdchk(apwt_pkg::IDX_RLDH, 8'h00);
    rdchk(apwt_pkg::IDX_RLDL, 8'h00);
    apb(1'b0, 10'h000, 8'h00);
    chk({31'h0, err}, 32'h00000001);
    apb(1'b1, apwt_pkg::IDX_TRIM, 8'hFF);
    rdchk(apwt_pkg::IDX_TRIM, 8'hFC);
    apb(1'b1, apwt_pkg::IDX_RLDL, 8'h04);
    rdchk(apwt_pkg::IDX_RLDL, 8'h04);
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h84);
    rdchk(apwt_pkg::IDX_CTRL, 8'h04);
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h00);
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h80);
    rdchk(apwt_pkg::IDX_CTRL, 8'h80);
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h8E);
    apb(1'b1, apwt_pkg::IDX_RLDL, 8'h10);
    rdchk(apwt_pkg::IDX_RLDL, 8'h04);
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h0E);
    apb(1'b0, apwt_pkg::IDX_CTRL, 8'h00);
    chk(rd & 32'h000000FE, 32'h0000008E);
    measure(8'h8E, 10, 1);
    rdchk(apwt_pkg::IDX_CTRL, 8'h81);
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h02);
    repeat (3) @(posedge i_clk);
    chk({31'h0, o_irq}, 32'h00000001);
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h03);
    rdchk(apwt_pkg::IDX_CTRL, 8'h02);
    chk({31'h0, o_irq}, 32'h00000000);
    r0 = rises;
    repeat (40) @(posedge i_clk);
    chk(32'(rises), 32'(r0));
    chk({31'h0, o_wave_pin}, 32'h00000000);
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h80);
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h84);
    repeat (40) @(posedge i_clk);
    chk(32'(rises), 32'(r0));
    rdchk(apwt_pkg::IDX_CTRL, 8'h85);
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h81);
    measure(8'h9C, 20, 10);
    // The stopping write ran with the timer enabled, so source select needs a second write
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h00);
    measure(8'h0C, 410, 41);
    apb(1'b1, apwt_pkg::IDX_TRIM, 8'h80);
    measure(8'h0C, 720, 72);
    apb(1'b1, apwt_pkg::IDX_TRIM, 8'h40);
    measure(8'h0C, 240, 24);
    apb(1'b1, apwt_pkg::IDX_RLDL, 8'h00);
    rdchk(apwt_pkg::IDX_RLDL, 8'h00);
    apb(1'b1, apwt_pkg::IDX_CTRL, 8'h80);
    measure(8'h8C, 2, 1);
    give_verdict();
  end
endmodule : apwt_top_test
